// File: verilog/eei_top.sv
// External edge interrupt: pin edge detect, flag, enables, wake and vectoring
`default_nettype none
module eei_top (
  input wire logic REF_CLK_I,
  input wire logic NRST_I,
  input wire logic EXT_INT_PIN_I,
  input wire logic EDGE_POLARITY_SELECT_I,
  input wire logic EXT_INT_ENABLE_I,
  input wire logic SLEEP_ENTER_I,
  input wire logic FLAG_CLEAR_I,
  input wire logic GLOBAL_SET_I,
  input wire logic GLOBAL_CLEAR_I,
  input wire logic [12:0] RETURN_PC_I,
  output logic EXT_INT_FLAG_O,
  output logic GLOBAL_INT_ENABLE_O,
  output logic SLEEPING_O,
  output logic WAKE_O,
  output logic INSTR_CYCLE_O,
  output logic VECTOR_O,
  output logic [12:0] VECTOR_PC_O,
  output logic PUSH_O,
  output logic [12:0] PUSH_ADDR_O
);
  logic pin_lvl, prev_r, edge_seen;
  logic [1:0] phase_r, phase_nxt;
  logic tick_r, tick_nxt;
  logic flag_r, flag_nxt, gie_r, gie_nxt;
  logic sleep_r, sleep_nxt, armed_r, armed_nxt, wake_r, wake_nxt;
  logic vec_r, vec_nxt, push_r, push_nxt;
  logic [12:0] push_addr_r, push_addr_nxt;
  logic [12:0] vpc_r, vpc_nxt;
  logic primed_r, primed_nxt;
  logic [1:0] lat_r, lat_nxt;
  eei_pkg::eei_state_type st_r, st_nxt;

  eei_sync u_sync (
    .clk_i(REF_CLK_I),
    .nrst_i(NRST_I),
    .pin_i(EXT_INT_PIN_I),
    .level_o(pin_lvl)
  );

  // Edge from successive filtered samples, polarity chosen here; masked until
  // the synchroniser has flushed its reset zeros, or a pin idling high would
  // look like a rising edge. A real edge inside that first window is lost.
  assign edge_seen = primed_r & (EDGE_POLARITY_SELECT_I ? (pin_lvl & ~prev_r)
                                                       : (~pin_lvl & prev_r));

  // Divider gives the instruction-cycle enable
  always_comb begin
    phase_nxt = phase_r + 2'h1;
    tick_nxt = (phase_r == eei_pkg::PHASE_LAST);
    primed_nxt = primed_r | tick_r;
  end

  always_comb begin
    flag_nxt = flag_r;
    gie_nxt = gie_r;
    sleep_nxt = sleep_r;
    armed_nxt = armed_r;
    wake_nxt = 1'b0;
    vec_nxt = 1'b0;
    push_nxt = 1'b0;
    push_addr_nxt = push_addr_r;
    vpc_nxt = 13'h0000;
    lat_nxt = lat_r;
    st_nxt = st_r;
    // Set beats clear so a coincident edge is never lost
    if (FLAG_CLEAR_I) begin
      flag_nxt = 1'b0;
    end
    if (edge_seen) begin
      flag_nxt = 1'b1;
    end
    if (GLOBAL_CLEAR_I) begin
      gie_nxt = 1'b0;
    end
    if (GLOBAL_SET_I) begin
      gie_nxt = 1'b1;
    end
    if (SLEEP_ENTER_I && !sleep_r) begin
      sleep_nxt = 1'b1;
      armed_nxt = EXT_INT_ENABLE_I;
    end
    if (sleep_r && armed_r && edge_seen) begin
      sleep_nxt = 1'b0;
      wake_nxt = 1'b1;
    end
    unique case (st_r)
      eei_pkg::EEI_RUN: begin
        // Request while flag is up or an edge is seen, and enables allow it
        if ((flag_r || edge_seen) && EXT_INT_ENABLE_I && gie_r
            && (!sleep_r || (armed_r && edge_seen))) begin
          st_nxt = eei_pkg::EEI_PEND;
          lat_nxt = 2'h0;
        end
      end
      eei_pkg::EEI_PEND: begin
        // Vector on the third instruction boundary after the request
        if (tick_r) begin
          lat_nxt = lat_r + 2'h1;
          if (lat_r == 2'(eei_pkg::LAT_MIN_CYC - 2'h1)) begin
            st_nxt = eei_pkg::EEI_VECT;
          end
        end
      end
      eei_pkg::EEI_VECT: begin
        vec_nxt = 1'b1;
        push_nxt = 1'b1;
        push_addr_nxt = RETURN_PC_I;
        vpc_nxt = eei_pkg::INT_VECTOR;
        gie_nxt = 1'b0;
        st_nxt = eei_pkg::EEI_RUN;
      end
      default: st_nxt = eei_pkg::EEI_RUN;
    endcase
  end

  always_ff @(posedge REF_CLK_I) begin
    if (!NRST_I) begin
      prev_r <= 1'b0;
      phase_r <= eei_pkg::PHASE_RST;
      tick_r <= 1'b0;
      flag_r <= eei_pkg::ICR_FLAG_RST;
      gie_r <= eei_pkg::ICR_GLOBAL_RST;
      sleep_r <= 1'b0;
      armed_r <= 1'b0;
      wake_r <= 1'b0;
      vec_r <= 1'b0;
      push_r <= 1'b0;
      push_addr_r <= 13'h0000;
      vpc_r <= 13'h0000;
      primed_r <= 1'b0;
      lat_r <= 2'h0;
      st_r <= eei_pkg::EEI_RUN;
    end else begin
      prev_r <= pin_lvl;
      phase_r <= phase_nxt;
      tick_r <= tick_nxt;
      flag_r <= flag_nxt;
      gie_r <= gie_nxt;
      sleep_r <= sleep_nxt;
      armed_r <= armed_nxt;
      wake_r <= wake_nxt;
      vec_r <= vec_nxt;
      push_r <= push_nxt;
      push_addr_r <= push_addr_nxt;
      vpc_r <= vpc_nxt;
      primed_r <= primed_nxt;
      lat_r <= lat_nxt;
      st_r <= st_nxt;
    end
  end

  assign EXT_INT_FLAG_O = flag_r;
  assign GLOBAL_INT_ENABLE_O = gie_r;
  assign SLEEPING_O = sleep_r;
  assign WAKE_O = wake_r;
  assign INSTR_CYCLE_O = tick_r;
  assign VECTOR_O = vec_r;
  assign VECTOR_PC_O = vpc_r;
  assign PUSH_O = push_r;
  assign PUSH_ADDR_O = push_addr_r;

  sequence s_edge_rise;
    !prev_r ##1 prev_r;
  endsequence

  AST_RISE_SETS_FLAG: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
    (primed_r && EDGE_POLARITY_SELECT_I && pin_lvl && !prev_r) |=> flag_r)
    else $error("rising edge did not set flag");
  AST_FALL_SETS_FLAG: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
    (primed_r && !EDGE_POLARITY_SELECT_I && !pin_lvl && prev_r) |=> flag_r)
    else $error("falling edge did not set flag");
  AST_FLAG_STICKY: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
    (flag_r && !FLAG_CLEAR_I) |=> flag_r)
    else $error("flag dropped without clear");
  AST_SET_WINS: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
    edge_seen |=> flag_r)
    else $error("edge lost against clear or enables");
  AST_NO_REQ_DISABLED: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
    (st_r == eei_pkg::EEI_RUN && !EXT_INT_ENABLE_I) |=> st_r == eei_pkg::EEI_RUN)
    else $error("request while disabled");
  AST_WAKE_ARMED: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
    $rose(wake_r) |-> $past(armed_r))
    else $error("wake without enable before sleep");
  AST_WAKE_ON_EDGE: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
    (sleep_r && armed_r && edge_seen) |=> (wake_r && !sleep_r))
    else $error("armed sleep missed a wake edge");
  AST_VEC_NEEDS_GIE: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
    (st_r == eei_pkg::EEI_RUN && !gie_r) |=> st_r == eei_pkg::EEI_RUN)
    else $error("vector without global enable");
  AST_TICK_PERIOD: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
    tick_r |=> !tick_r [*3] ##1 tick_r)
    else $error("instruction cycle not four clocks");
  AST_SERVICE: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
    vec_r |-> (PUSH_O && VECTOR_PC_O == eei_pkg::INT_VECTOR && !gie_r))
    else $error("service step incomplete");
  AST_PUSH_ADDR: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
    (st_r == eei_pkg::EEI_VECT) |=> (vec_r && PUSH_ADDR_O == $past(RETURN_PC_I)))
    else $error("return address not pushed");
  // Three ticks are counted in the pending state, so 10 to 13 clocks by phase
  AST_LATENCY: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
    $rose(st_r == eei_pkg::EEI_PEND) |-> ##[10:13] vec_r)
    else $error("vector latency out of range");
  AST_EDGE_SAMPLE: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
    s_edge_rise |-> ($past(EXT_INT_PIN_I, 4) && $past(EXT_INT_PIN_I, 5)))
    else $error("edge sampling broken");
  AST_SYNC_AGREE: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
    $changed(pin_lvl) |-> (pin_lvl == $past(EXT_INT_PIN_I, 3)
                           && pin_lvl == $past(EXT_INT_PIN_I, 4)))
    else $error("filtered level moved without two agreeing samples");
endmodule // eei_top
`default_nettype wire

// File: verilog/eei_pkg.sv
// Package of constants for the external edge interrupt block
`default_nettype none
package eei_pkg;
  localparam int unsigned OPT_EDGE_POL_BIT = 6;
  localparam int unsigned ICR_FLAG_BIT = 1;
  localparam int unsigned ICR_ENABLE_BIT = 4;
  localparam int unsigned ICR_GLOBAL_BIT = 7;
  localparam logic [12:0] INT_VECTOR = 13'h0004;
  localparam int unsigned OSC_PER_INSTR = 4;
  localparam logic [1:0] PHASE_RST = 2'h0;
  localparam logic [1:0] PHASE_LAST = 2'(OSC_PER_INSTR - 1);
  localparam logic [1:0] LAT_MIN_CYC = 2'h3;
  localparam logic [2:0] LAT_MAX_CYC = 3'h4;
  localparam logic ICR_FLAG_RST = 1'b0;
  localparam logic ICR_GLOBAL_RST = 1'b0;
  typedef enum logic [1:0] {
    EEI_RUN = 2'b00,
    EEI_PEND = 2'b01,
    EEI_VECT = 2'b11
  } eei_state_type;
endpackage : eei_pkg
`default_nettype wire

// File: verilog/eei_sync.sv
// Three-stage pin synchroniser with agreement filter
`default_nettype none
module eei_sync (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic pin_i,
  output logic level_o
);
  logic s1_r, s2_r, s3_r, lvl_r;
  logic lvl_nxt;

  always_comb begin
    lvl_nxt = lvl_r;
    // Only the later two stages vote; the first may be metastable
    if (s2_r == s3_r) begin
      lvl_nxt = s2_r;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      lvl_r <= 1'b0;
    end else begin
      s1_r <= pin_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      lvl_r <= lvl_nxt;
    end
  end

  assign level_o = lvl_r;
endmodule // eei_sync
`default_nettype wire

// File: sim/eei_pin_model.sv
// Model of the outside logic that drives the interrupt pin
`default_nettype none
module eei_pin_model (
  input wire logic clk_i,
  input wire logic level_i,
  output logic pin_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Registered on the rising edge, so the pin moves at a sampling instant but only after it is sampled
  always_ff @(posedge clk_i) pin_o <= level_i;
endmodule // eei_pin_model
`default_nettype wire

// File: sim/tb.sv
// Self-checking bench for the external edge interrupt block
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, nrst = 0, lvl = 0, pol = 1, en = 1, slp = 0, fclr = 0, gset = 0, gclr = 0;
  logic pin, flag, global_int_enable, sleeping, wake, tick, vec, push, sv, sw;
  logic [12:0] vpc, paddr, cpc, cpush, rpc = 13'h0ABC;
  int fails = 0, tests_run = 0, ticks, per, last;
  initial forever #4 clk = ~clk;
  eei_pin_model u_eei_pin_model (.clk_i(clk), .level_i(lvl), .pin_o(pin));
  eei_top u_eei_top (
    .REF_CLK_I(clk), .NRST_I(nrst), .EXT_INT_PIN_I(pin), .EDGE_POLARITY_SELECT_I(pol),
    .EXT_INT_ENABLE_I(en), .SLEEP_ENTER_I(slp), .FLAG_CLEAR_I(fclr),
    .GLOBAL_SET_I(gset), .GLOBAL_CLEAR_I(gclr), .RETURN_PC_I(rpc),
    .EXT_INT_FLAG_O(flag), .GLOBAL_INT_ENABLE_O(global_int_enable), .SLEEPING_O(sleeping),
    .WAKE_O(wake), .INSTR_CYCLE_O(tick), .VECTOR_O(vec), .VECTOR_PC_O(vpc),
    .PUSH_O(push), .PUSH_ADDR_O(paddr)
  );
  task check(input logic [12:0] seen, input logic [12:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // Bounded watch of the outputs; the first vector is captured with its push
  task run(input int n);
    sv = 0;
    sw = 0;
    ticks = 0;
    last = 0;
    for (int i = 1; i <= n; i++) begin
      @(posedge clk);
      if (tick === 1'b1) begin
        per = i - last;
        last = i;
        if (flag === 1'b1 && !sv) ticks++;
      end
      if (wake === 1'b1) sw = 1;
      if (vec === 1'b1 && !sv) begin
        sv = 1;
        cpc = vpc;
        cpush = (push === 1'b1) ? paddr : 13'h1FFF;
      end
    end
  endtask
  task pulse(input int k);
    fclr <= (k == 0);
    gset <= (k == 1);
    slp <= (k == 2);
    gclr <= (k == 3);
    @(posedge clk);
    {fclr, gset, slp, gclr} <= 4'h0;
    @(posedge clk);
  endtask
  task end_of_test;
    $display("comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    nrst <= 1;
    @(posedge clk);
    check(flag, 0);
    check(global_int_enable, 0);
    run(4);
    pulse(1);
    lvl <= 1;
    run(40);
    check(flag, 1);
    check(sv, 1);
    check(cpc, 13'h0004);
    check(cpush, 13'h0ABC);
    check(global_int_enable, 0);
    check(13'(per), 13'h0004);
    check(ticks inside {3, 4}, 1);
    pulse(0);
    check(flag, 0);
    lvl <= 0;
    run(40);
    check(flag, 0);
    pol <= 0;
    lvl <= 1;
    run(40);
    check(flag, 0);
    lvl <= 0;
    run(40);
    check(flag, 1);
    pulse(0);
    en <= 0;
    pulse(1);
    lvl <= 1;
    run(40);
    lvl <= 0;
    run(40);
    check(flag, 1);
    check(sv, 0);
    pulse(0);
    pulse(3);
    rpc <= 13'h1555;
    // Pass 0 sleeps without global enable, 1 with it, 2 with the local enable off
    for (int g = 0; g < 3; g++) begin
      en <= (g < 2);
      if (g == 1) pulse(1);
      pulse(2);
      check(sleeping, 1);
      lvl <= 1;
      run(40);
      lvl <= 0;
      run(40);
      check(sw, g < 2);
      check(sv, g == 1);
      check(sleeping, g == 2);
      if (g == 1) check(cpush, 13'h1555);
      pulse(0);
    end
    end_of_test();
  end
endmodule // tb
`default_nettype wire
